// File: svm_analog_model.sv
// stand-in for the analog comparator and bandgap behind the supply monitor
`timescale 1ns/10ps
`default_nettype none

module svm_analog_model #(
   parameter int SETTLE = 5
) (
   input  wire logic       clk,            // system clock
   input  wire logic       detector_power, // detector enable
   input  wire logic       refgen_on,      // reference enable
   input  wire logic [2:0] trip_level_sel, // trip code
   input  var  int         supply_mv,      // supply in millivolts
   output logic            cmp_low         // 1 = supply low
);
   int   lvl_mv [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
   int   on_cnt     = 0;
   logic junk       = 1'b0;

   // powered time; comparator needs detector and reference both up
   always @(posedge clk) begin
      junk   <= ~junk;
      on_cnt <= (detector_power && refgen_on) ? on_cnt + 1 : 0;
   end

   // output is a toggling pattern until settled, so stale flags cannot pass
   always_comb begin
      if (on_cnt > SETTLE) begin
         cmp_low = supply_mv < lvl_mv[trip_level_sel];
      end else begin
         cmp_low = junk;
      end
   end
endmodule // svm_analog_model
`default_nettype wire

// File: svm_ctrl.sv
// module: control, status and delayed interrupt logic of the supply monitor
`timescale 1ns/10ps
`default_nettype none

module svm_ctrl #(
   parameter int IRQ_DELAY_CYC = svm_pkg::IRQ_DELAY_CYC,
   parameter int SETTLE_CYC    = svm_pkg::SETTLE_CYC
) (
   input  wire logic [3:0] addr,                 // register address
   input  wire logic       clk,                  // system clock
   input  wire logic       rst,                  // async reset, active high
   input  wire logic [7:0] wdata,                // write data
   input  wire logic       wr_en,                // write strobe
   input  wire logic       rd_en,                // read strobe
   output logic      [7:0] rdata,                // read data, cycle after rd_en
   input  wire logic       cmp_low,              // async comparator, 1 = supply low
   input  wire logic       sleep_mode,           // core in sleep
   input  wire logic       idle_mode,            // core in idle
   input  wire logic       lowv_reset_function,  // low-voltage reset enabled
   output logic            detector_power,       // analog detector enable
   output logic            refgen_on,            // bandgap reference enable
   output logic            refgen_out_on,        // reference voltage output enable
   output logic      [2:0] trip_level_sel,       // comparator trip level
   output logic            lowv_irq_request,     // request to shared interrupt
   output logic            irq,                  // masked interrupt level
   output logic            wake                  // idle wake-up pulse
);

   // checks at the bottom run on the system clock and rest while reset is high
   default clocking cb_chk @(posedge clk);
   endclocking
   default disable iff (rst);

   localparam int CNT_MAX = (IRQ_DELAY_CYC > SETTLE_CYC) ? IRQ_DELAY_CYC : SETTLE_CYC;
   localparam int CNT_W   = $clog2(CNT_MAX + 1);
   localparam logic [CNT_W-1:0] DLY_N = CNT_W'(IRQ_DELAY_CYC);
   localparam logic [CNT_W-1:0] STL_N = CNT_W'(SETTLE_CYC);

   // address match, shared by the read and write decoders
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   logic [7:0]           ctrl_reg;
   logic [2:0]           sts_reg;
   logic [2:0]           sts_next;
   logic [2:0]           en_reg;
   logic [2:0]           set_bits;
   logic [2:0]           clr_bits;
   logic                 cmp_s1_reg;
   logic                 cmp_s2_reg;
   logic                 lowv_flag_reg;
   logic                 flag_d_reg;
   logic                 active;
   logic                 flag_rise;
   logic                 hw_set;
   logic [CNT_W-1:0]     dly_cnt_reg;
   logic [CNT_W-1:0]     stl_cnt_reg;
   logic                 settled_reg;
   logic                 settled_d_reg;
   svm_pkg::svm_state_t  state_reg;
   logic [7:0]           rd_mux;
   logic [7:0]           rdata_reg;
   logic                 det_reg;
   logic                 ref_reg;
   logic                 ref_out_reg;
   logic [2:0]           trip_reg;
   logic                 irq_reg;
   logic                 wake_reg;

   // detector runs only while enabled and not asleep
   assign active = ctrl_reg[svm_pkg::DET_ON_BIT] & ~sleep_mode;

   // control register write; only the low five bits hold state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= svm_pkg::CTRL_RESET;
      end else if (wr_en && hit(addr, svm_pkg::ADDR_CONTROL)) begin
         ctrl_reg <= wdata & svm_pkg::CTRL_RW_MASK;
      end
   end

   // interrupt enable register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_reg <= svm_pkg::IRQ_EN_RESET;
      end else if (wr_en && hit(addr, svm_pkg::ADDR_IRQ_ENABLE)) begin
         en_reg <= wdata[2:0];
      end
   end

   // comparator is asynchronous: two flops before anything looks at it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmp_s1_reg <= 1'b0;
         cmp_s2_reg <= 1'b0;
      end else begin
         cmp_s1_reg <= cmp_low;
         cmp_s2_reg <= cmp_s1_reg;
      end
   end

   // low supply flag, forced low while the detector is off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowv_flag_reg <= 1'b0;
         flag_d_reg    <= 1'b0;
      end else begin
         lowv_flag_reg <= active & cmp_s2_reg;
         flag_d_reg    <= lowv_flag_reg;
      end
   end

   assign flag_rise = lowv_flag_reg & ~flag_d_reg;

   // settle timer: marks when the flag becomes trustworthy after enabling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stl_cnt_reg   <= '0;
         settled_reg   <= 1'b0;
         settled_d_reg <= 1'b0;
      end else begin
         settled_d_reg <= settled_reg;
         if (!active) begin
            stl_cnt_reg <= '0;
            settled_reg <= 1'b0;
         end else if (stl_cnt_reg != STL_N) begin
            stl_cnt_reg <= stl_cnt_reg + 1'b1;
         end else begin
            settled_reg <= 1'b1;
         end
      end
   end

   // delay sequencer: the flag must stay high for the whole delay;
   // a supply hovering near the level gives flag chatter, and each drop restarts it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg   <= svm_pkg::ST_IDLE;
         dly_cnt_reg <= '0;
      end else begin
         case (state_reg)
            svm_pkg::ST_IDLE: begin
               dly_cnt_reg <= '0;
               if (active && lowv_flag_reg) begin
                  state_reg   <= svm_pkg::ST_DELAY;
                  dly_cnt_reg <= CNT_W'(1);
               end
            end
            svm_pkg::ST_DELAY: begin
               if (!active || !lowv_flag_reg) begin
                  state_reg   <= svm_pkg::ST_IDLE;
                  dly_cnt_reg <= '0;
               end else if (dly_cnt_reg == DLY_N) begin
                  state_reg <= svm_pkg::ST_FIRED;
               end else begin
                  dly_cnt_reg <= dly_cnt_reg + 1'b1;
               end
            end
            svm_pkg::ST_FIRED: begin
               if (!active || !lowv_flag_reg) begin
                  state_reg <= svm_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg   <= svm_pkg::ST_IDLE;
               dly_cnt_reg <= '0;
            end
         endcase
      end
   end

   // hardware request: flag has been high for the full delay
   assign hw_set = (state_reg == svm_pkg::ST_DELAY) && active
                   && lowv_flag_reg && (dly_cnt_reg == DLY_N);

   // sticky status: hardware events and software presets set, clear register clears
   always_comb begin
      set_bits = '0;
      clr_bits = '0;
      set_bits[svm_pkg::IRQ_REQ_BIT]     = hw_set;
      set_bits[svm_pkg::IRQ_RISE_BIT]    = flag_rise;
      set_bits[svm_pkg::IRQ_SETTLED_BIT] = settled_reg & ~settled_d_reg;
      if (wr_en && hit(addr, svm_pkg::ADDR_IRQ_SET)) begin
         set_bits = set_bits | wdata[2:0];
      end
      if (wr_en && hit(addr, svm_pkg::ADDR_IRQ_CLEAR)) begin
         clr_bits = wdata[2:0];
      end
      // a set arriving with the clear wins, so no event is lost
      sts_next = (sts_reg & ~clr_bits) | set_bits;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_reg <= svm_pkg::IRQ_STS_RESET;
      end else begin
         sts_reg <= sts_next;
      end
   end

   // wake only on a hardware request into an empty flag, so a preset blocks it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= hw_set & ~sts_reg[svm_pkg::IRQ_REQ_BIT] & idle_mode;
      end
   end

   // masked interrupt level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(sts_reg & en_reg);
      end
   end

   // analog controls, registered so the pins never glitch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         det_reg     <= 1'b0;
         ref_reg     <= 1'b0;
         ref_out_reg <= 1'b0;
         trip_reg    <= svm_pkg::TRIP_2V0;
      end else begin
         det_reg     <= active;
         ref_reg     <= active | lowv_reset_function
                        | ctrl_reg[svm_pkg::REFGEN_OUT_BIT];
         ref_out_reg <= ctrl_reg[svm_pkg::REFGEN_OUT_BIT];
         trip_reg    <= ctrl_reg[svm_pkg::TRIP_LSB +: svm_pkg::TRIP_W];
      end
   end

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      rd_mux = 8'h00;
      if (hit(addr, svm_pkg::ADDR_CONTROL)) begin
         rd_mux = ctrl_reg & svm_pkg::CTRL_RW_MASK;
         rd_mux[svm_pkg::LOWV_FLAG_BIT] = lowv_flag_reg;
      end else if (hit(addr, svm_pkg::ADDR_IRQ_STATUS)) begin
         rd_mux[2:0] = sts_reg;
      end else if (hit(addr, svm_pkg::ADDR_IRQ_ENABLE)) begin
         rd_mux[2:0] = en_reg;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd_en ? rd_mux : 8'h00;
      end
   end

   assign rdata            = rdata_reg;
   assign detector_power   = det_reg;
   assign refgen_on        = ref_reg;
   assign refgen_out_on    = ref_out_reg;
   assign trip_level_sel   = trip_reg;
   assign lowv_irq_request = sts_reg[svm_pkg::IRQ_REQ_BIT];
   assign irq              = irq_reg;
   assign wake             = wake_reg;

   // helper for checks: consecutive cycles the flag has been high, saturating
   logic [CNT_W-1:0] hi_cnt_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_cnt_reg <= '0;
      end else if (!lowv_flag_reg) begin
         hi_cnt_reg <= '0;
      end else if (hi_cnt_reg != {CNT_W{1'b1}}) begin
         hi_cnt_reg <= hi_cnt_reg + 1'b1;
      end
   end

   sequence s_ctrl_read;
      rd_en && hit(addr, svm_pkg::ADDR_CONTROL);
   endsequence
   sequence s_flag_fed;
      active ##1 active ##1 active;
   endsequence

   property p_trip_follow;
      1'b1 |=> trip_level_sel == $past(ctrl_reg[2:0]);
   endproperty
   a_trip_follow: assert property (p_trip_follow)
      else $error("trip level output does not follow control field");
   property p_flag_read;
      s_ctrl_read |=> rdata[5] == $past(lowv_flag_reg);
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("control read does not show the low supply flag");
   property p_det_on;
      ctrl_reg[4] && !sleep_mode |=> detector_power;
   endproperty
   a_det_on: assert property (p_det_on)
      else $error("detector not powered while enabled and awake");
   property p_ref_out;
      $rose(ctrl_reg[3]) |=> refgen_out_on && refgen_on;
   endproperty
   a_ref_out: assert property (p_ref_out)
      else $error("reference output not enabled after setting its bit");
   property p_ref_on;
      (active || lowv_reset_function || ctrl_reg[3]) |=> refgen_on;
   endproperty
   a_ref_on: assert property (p_ref_on)
      else $error("reference off while a user needs it");
   property p_reserved_zero;
      s_ctrl_read |=> rdata[7:6] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unused control bits read nonzero");
   property p_sync_path;
      s_flag_fed |=> lowv_flag_reg == $past(cmp_low, 3);
   endproperty
   a_sync_path: assert property (p_sync_path)
      else $error("flag does not follow comparator after two sync stages");
   property p_sleep_off;
      sleep_mode |=> !detector_power ##0 !lowv_flag_reg;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("detector or flag active during sleep");
   property p_irq_delay;
      hw_set |-> hi_cnt_reg >= DLY_N && hi_cnt_reg <= DLY_N;
   endproperty
   a_irq_delay: assert property (p_irq_delay)
      else $error("request raised at the wrong distance from flag rise");
   property p_req_sets;
      hw_set |=> lowv_irq_request ##1 (irq == $past(en_reg[0]) || $past(sts_reg[2:1] & en_reg[2:1]) != 2'b00);
   endproperty
   a_req_sets: assert property (p_req_sets)
      else $error("request flag or masked interrupt missing after request");
   property p_wake;
      wake |-> $past(hw_set) && $past(idle_mode) && !$past(lowv_irq_request);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake without a fresh request in idle");
   // both the sequencer and the flag must be back at rest one cycle after shutdown
   property p_cancel;
      !active |=> state_reg == svm_pkg::ST_IDLE && !lowv_flag_reg;
   endproperty
   a_cancel: assert property (p_cancel)
      else $error("delay not cancelled while detector off");

endmodule  // svm_ctrl

`default_nettype wire

// File: svm_pkg.sv
// package: register map, field layout and timing for the supply monitor control block
package svm_pkg;

   // register bus shape
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [3:0] ADDR_CONTROL    = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
   localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h2;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
   localparam logic [3:0] ADDR_IRQ_SET    = 4'h4;

   // lowv_control fields
   localparam int TRIP_LSB       = 0;
   localparam int TRIP_W         = 3;
   localparam int REFGEN_OUT_BIT = 3;
   localparam int DET_ON_BIT     = 4;
   localparam int LOWV_FLAG_BIT  = 5;
   localparam logic [7:0] CTRL_RW_MASK = 8'h1F;
   localparam logic [7:0] CTRL_RESET   = 8'h00;

   // interrupt status / clear / enable / set layout
   localparam int IRQ_W           = 3;
   localparam int IRQ_REQ_BIT     = 0;
   localparam int IRQ_RISE_BIT    = 1;
   localparam int IRQ_SETTLED_BIT = 2;
   localparam logic [2:0] IRQ_STS_RESET = 3'h0;
   localparam logic [2:0] IRQ_EN_RESET  = 3'h0;

   // timing
   localparam int CLK_PERIOD_NS  = 50;
   localparam int IRQ_DELAY_NS   = 100000;
   localparam int SETTLE_NS      = 150000;
   // least times round up to whole cycles
   localparam int IRQ_DELAY_CYC  = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // trip level codes, lowest to highest
   typedef enum logic [2:0] {
      TRIP_2V0 = 3'b000,
      TRIP_2V2 = 3'b001,
      TRIP_2V4 = 3'b010,
      TRIP_2V7 = 3'b011,
      TRIP_3V0 = 3'b100,
      TRIP_3V3 = 3'b101,
      TRIP_3V6 = 3'b110,
      TRIP_4V0 = 3'b111
   } svm_trip_t;

   // interrupt delay sequencer
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DELAY = 2'b01,
      ST_FIRED = 2'b10
   } svm_state_t;

endpackage

// File: tb_top.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   localparam int N = 4; // shortened interrupt delay
   logic [3:0] addr = 4'h0;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] rdata;
   logic       cmp_low;
   logic       sleep_mode = 1'b0;
   logic       idle_mode = 1'b0;
   logic       lowv_reset_function = 1'b0;
   logic       detector_power;
   logic       refgen_on;
   logic       refgen_out_on;
   logic [2:0] trip_level_sel;
   logic       lowv_irq_request;
   logic       irq;
   logic       wake;
   int         supply_mv = 4500;
   int         miscompares = 0;
   int         n_checks = 0;
   int         cycles = 0;
   int         wakes = 0;
   int         lvl_mv [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

   svm_ctrl #(.IRQ_DELAY_CYC(N), .SETTLE_CYC(5)) i_svm_ctrl (
      .addr(addr), .clk(clk), .rst(rst), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .cmp_low(cmp_low), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
      .lowv_reset_function(lowv_reset_function), .detector_power(detector_power),
      .refgen_on(refgen_on), .refgen_out_on(refgen_out_on), .trip_level_sel(trip_level_sel),
      .lowv_irq_request(lowv_irq_request), .irq(irq), .wake(wake));

   svm_analog_model #(.SETTLE(5)) i_svm_analog_model (
      .clk(clk), .detector_power(detector_power), .refgen_on(refgen_on),
      .trip_level_sel(trip_level_sel), .supply_mv(supply_mv), .cmp_low(cmp_low));

   always #25 clk = ~clk;

   // wake pulses are counted here since they stand one cycle only; hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wake === 1'b1) begin
         wakes <= wakes + 1;
      end
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {7'h00, exp}, {7'h00, got});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic set_supply(input int mv);
      @(posedge clk);
      supply_mv <= mv;
   endtask

   task automatic t_regs();
      rd(svm_pkg::ADDR_CONTROL, 8'h00, "control reset");
      rd(svm_pkg::ADDR_IRQ_STATUS, 8'h00, "status reset");
      rd(svm_pkg::ADDR_IRQ_ENABLE, 8'h00, "enable reset");
      rd(4'hF, 8'h00, "unmapped read");
      wr(svm_pkg::ADDR_CONTROL, 8'hFF);
      wr(4'hF, 8'h00);
      cyc(12);
      rd(svm_pkg::ADDR_CONTROL, 8'h1F, "control all set");
      chk1("detector_power", 1'b1, detector_power);
      chk1("refgen_out_on", 1'b1, refgen_out_on);
      chk1("refgen_on", 1'b1, refgen_on);
      wr(svm_pkg::ADDR_CONTROL, 8'h08);
      cyc(2);
      chk1("detector_power off", 1'b0, detector_power);
      chk1("refgen_on by output bit", 1'b1, refgen_on);
      wr(svm_pkg::ADDR_CONTROL, 8'hE0);
      cyc(2);
      chk1("refgen_on all off", 1'b0, refgen_on);
      @(posedge clk);
      lowv_reset_function <= 1'b1;
      cyc(2);
      chk1("refgen_on by reset function", 1'b1, refgen_on);
      @(posedge clk);
      lowv_reset_function <= 1'b0;
      rd(svm_pkg::ADDR_CONTROL, 8'h00, "upper bits");
      $display("test regs done");
   endtask

   // every trip code: just under its level trips, just over it does not
   task automatic t_trip();
      for (int c = 0; c < 8; c++) begin
         wr(svm_pkg::ADDR_CONTROL, 8'h10 | 8'(c));
         set_supply(lvl_mv[c] - 50);
         cyc(12);
         rd(svm_pkg::ADDR_CONTROL, 8'h30 | 8'(c), "flag low supply");
         set_supply(lvl_mv[c] + 50);
         cyc(5);
         rd(svm_pkg::ADDR_CONTROL, 8'h10 | 8'(c), "flag good supply");
         chk("trip_level_sel", 8'(c), {5'h00, trip_level_sel});
      end
      $display("test trip done");
   endtask

   task automatic t_irq();
      int w0;
      int k;
      wr(svm_pkg::ADDR_CONTROL, 8'h14);
      set_supply(3300);
      cyc(12);
      wr(svm_pkg::ADDR_IRQ_CLEAR, 8'h07);
      wr(svm_pkg::ADDR_IRQ_ENABLE, 8'h01);
      idle_mode <= 1'b1;
      w0 = wakes;
      set_supply(2900);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (lowv_irq_request !== 1'b1 && k < 40);
      chk("request delay", 8'(N + 4), 8'(k));
      cyc(1);
      chk1("irq", 1'b1, irq);
      chk("wake count", 8'h01, 8'(wakes - w0));
      rd(svm_pkg::ADDR_IRQ_STATUS, 8'h03, "status with request");
      wr(svm_pkg::ADDR_IRQ_CLEAR, 8'h01);
      cyc(N + 4);
      chk1("request once", 1'b0, lowv_irq_request);
      chk1("irq cleared", 1'b0, irq);
      wr(svm_pkg::ADDR_IRQ_ENABLE, 8'h00);
      wr(svm_pkg::ADDR_IRQ_SET, 8'h01);
      cyc(2);
      chk1("request set", 1'b1, lowv_irq_request);
      chk1("irq masked", 1'b0, irq);
      $display("test irq done");
   endtask

   // a preset request flag keeps the detector from waking an idle core
   task automatic t_preset();
      int w0;
      set_supply(3300);
      cyc(6);
      wr(svm_pkg::ADDR_IRQ_CLEAR, 8'h07);
      wr(svm_pkg::ADDR_IRQ_SET, 8'h01);
      w0 = wakes;
      set_supply(2900);
      cyc(N + 8);
      chk("wake blocked", 8'h00, 8'(wakes - w0));
      chk1("request held", 1'b1, lowv_irq_request);
      $display("test preset done");
   endtask

   task automatic t_sleep();
      rd(svm_pkg::ADDR_CONTROL, 8'h34, "flag before sleep");
      wr(svm_pkg::ADDR_IRQ_CLEAR, 8'h07);
      set_supply(3300);
      cyc(4);
      set_supply(2900);
      sleep_mode <= 1'b1;
      cyc(2);
      chk1("detector_power asleep", 1'b0, detector_power);
      cyc(N + 6);
      chk1("request asleep", 1'b0, lowv_irq_request);
      rd(svm_pkg::ADDR_CONTROL, 8'h14, "flag asleep");
      @(posedge clk);
      sleep_mode <= 1'b0;
      cyc(14);
      rd(svm_pkg::ADDR_CONTROL, 8'h34, "flag after sleep");
      rd(svm_pkg::ADDR_IRQ_STATUS, 8'h07, "status after sleep");
      wr(svm_pkg::ADDR_IRQ_CLEAR, 8'h07);
      set_supply(3300);
      cyc(4);
      set_supply(2900);
      wr(svm_pkg::ADDR_CONTROL, 8'h04);
      cyc(N + 6);
      chk1("request after disable", 1'b0, lowv_irq_request);
      rd(svm_pkg::ADDR_CONTROL, 8'h04, "flag disabled");
      $display("test sleep done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_trip();
      t_irq();
      t_preset();
      t_sleep();
      results();
   end
endmodule // tb_top
`default_nettype wire
